// file: rtl/eic_cfg.svh
`ifndef EIC_CFG_SVH
`define EIC_CFG_SVH

// ------------------------------------------------------------
// Special function register addresses
// ------------------------------------------------------------
`define EIC_ADDR_PRIO_TWO     8'hf7
`define EIC_ADDR_PIN_CONFIG   8'he4
`define EIC_ADDR_TIMER_CTRL   8'h88

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define EIC_RST_PRIO_TWO      4'h0
`define EIC_RST_PIN_CONFIG    8'h01
`define EIC_RST_TRIGGER       2'h0
`define EIC_RST_BYTE          8'h00

// ------------------------------------------------------------
// Priority register fields
// ------------------------------------------------------------
`define EIC_PRIO_SPI_BIT      3
`define EIC_PRIO_RTC_BIT      2
`define EIC_PRIO_MATCH_BIT    1
`define EIC_PRIO_WARN_BIT     0
`define EIC_PRIO_W            4

// ------------------------------------------------------------
// Pin configuration fields
// ------------------------------------------------------------
`define EIC_CFG_ONE_POL_BIT   7
`define EIC_CFG_ONE_SEL_HI    6
`define EIC_CFG_ONE_SEL_LO    4
`define EIC_CFG_ZERO_POL_BIT  3
`define EIC_CFG_ZERO_SEL_HI   2
`define EIC_CFG_ZERO_SEL_LO   0

// ------------------------------------------------------------
// Timer control fields owned here
// ------------------------------------------------------------
`define EIC_TC_ZERO_TRIG_BIT  0
`define EIC_TC_ZERO_PEND_BIT  1
`define EIC_TC_ONE_TRIG_BIT   2
`define EIC_TC_ONE_PEND_BIT   3

`endif

// file: rtl/eic_pkg.sv
package eic_pkg;

    typedef enum logic {
        EIC_LEVEL = 1'b0,
        EIC_EDGE  = 1'b1
    } eic_trig_e;

    typedef struct packed {
        logic       active_q;
        logic       pending;
    } eic_chan_s;

    typedef struct packed {
        logic [3:0] prio;
        logic [7:0] pin_cfg;
        logic [1:0] trig;
        logic [7:0] rdata;
    } eic_top_s;

endpackage

// file: rtl/eic_channel.sv
`timescale 1ns/1ns
`include "eic_cfg.svh"

module eic_channel #(
    parameter int PIN_COUNT = 8,
    parameter int SEL_W     = 3
) (
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    // Configuration
    input  wire logic [SEL_W-1:0]     pin_select_in,
    input  wire logic                 polarity_in,
    input  wire eic_pkg::eic_trig_e   trigger_type_in,
    // Port pins and CPU events
    input  wire logic [PIN_COUNT-1:0] port_pins_in,
    input  wire logic                 vector_ack_in,
    input  wire logic                 flag_wr_in,
    input  wire logic                 flag_wdata_in,
    // Pending flag
    output logic                      pending_out
);
    import eic_pkg::*;

    if ((1 << SEL_W) != PIN_COUNT) begin : g_check
        $error("PIN_COUNT must equal 2**SEL_W");
    end

    eic_chan_s st;
    eic_chan_s next_st;
    logic      active;

    // ------------------------------------------------------------
    // Pin sensing
    // ------------------------------------------------------------
    // Read-only tap on the port: the crossbar owner keeps the pin [RL7] [RL14]
    assign active = ~(port_pins_in[pin_select_in] ^ polarity_in); // [RL6]

    always_comb begin
        next_st = st;
        next_st.active_q = active;
        if (trigger_type_in == EIC_LEVEL) begin
            next_st.pending = active; // [RL10] [RL6]
        end else begin
            // Clear first so a same-cycle edge wins
            if (vector_ack_in) begin
                next_st.pending = 1'b0; // [RL9]
            end
            if (flag_wr_in) begin
                next_st.pending = flag_wdata_in;
            end
            if (active && !st.active_q) begin
                next_st.pending = 1'b1; // [RL13]
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pending_out = st.pending;

endmodule

// file: rtl/eic_top.sv
`timescale 1ns/1ns
`include "eic_cfg.svh"

// Notes on behaviour
// RL1: Priority register bits 7:4 read zero; writes there are ignored.
// RL2: Priority bit 3 sets second serial port interrupt high priority.
// RL3: Priority bit 2 sets oscillator-fail interrupt high priority.
// RL4: Priority bit 1 sets port match interrupt high priority.
// RL5: Priority bit 0 sets supply warning interrupt high priority.
// RL6: Trigger bit 1 means edge, 0 level; polarity 1 high, 0 low.
// RL7: Inputs watch port pins without disturbing crossbar peripherals.
// RL8: Pending flags sit at timer control bits 1 and 3.
// RL9: Edge mode pending clears when the CPU vectors to the routine.
// RL10: Level mode pending follows the pin's active level.
// RL11: Level source holds its input active until recognised.
// RL12: Level source releases input before the routine ends.
// RL13: Edge mode sets pending on each inactive-to-active transition.
// RL14: Pin-select fields 6:4 and 2:0 pick port 0 pin n.
module eic_top #(
    parameter int PIN_COUNT = 8,
    parameter int SEL_W     = 3
) (
    // Clock and reset
    input  wire logic                 ref_clk_in,
    input  wire logic                 rst_n_in,
    // Special function register access
    input  wire logic [7:0]           sfr_addr_in,
    input  wire logic                 sfr_wr_in,
    input  wire logic [7:0]           sfr_wdata_in,
    input  wire logic                 sfr_rd_in,
    output logic [7:0]                sfr_rdata_out,
    // Port 0 pins, sensed only
    input  wire logic [PIN_COUNT-1:0] port_pins_in,
    // CPU vectoring to each external routine
    input  wire logic                 ext_irq_zero_vector_in,
    input  wire logic                 ext_irq_one_vector_in,
    // Interrupt requests
    output logic                      ext_irq_zero_pending_out,
    output logic                      ext_irq_one_pending_out,
    // Priority levels for the interrupt arbiter
    output logic                      second_serial_port_priority_out,
    output logic                      rtc_osc_fail_priority_out,
    output logic                      port_match_priority_out,
    output logic                      supply_warning_priority_out
);
    import eic_pkg::*;

    if (SEL_W != `EIC_CFG_ZERO_SEL_HI - `EIC_CFG_ZERO_SEL_LO + 1) begin : g_chk
        $error("SEL_W must match the pin-select field width");
    end

    eic_top_s   st;
    eic_top_s   next_st;
    logic       wr_prio;
    logic       wr_cfg;
    logic       wr_tc;
    logic       ext_irq_zero_pending;
    logic       ext_irq_one_pending;
    logic [7:0] read_mux;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wr_prio = sfr_wr_in && (sfr_addr_in == `EIC_ADDR_PRIO_TWO);
    assign wr_cfg  = sfr_wr_in && (sfr_addr_in == `EIC_ADDR_PIN_CONFIG);
    assign wr_tc   = sfr_wr_in && (sfr_addr_in == `EIC_ADDR_TIMER_CTRL);

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Timer bits of the shared register belong elsewhere and read zero here
    always_comb begin
        read_mux = `EIC_RST_BYTE;
        case (sfr_addr_in)
            `EIC_ADDR_PRIO_TWO: begin
                read_mux[`EIC_PRIO_W-1:0] = st.prio; // [RL1]
            end
            `EIC_ADDR_PIN_CONFIG: begin
                read_mux = st.pin_cfg;
            end
            `EIC_ADDR_TIMER_CTRL: begin
                read_mux[`EIC_TC_ZERO_TRIG_BIT] = st.trig[0];
                read_mux[`EIC_TC_ZERO_PEND_BIT] = ext_irq_zero_pending; // [RL8]
                read_mux[`EIC_TC_ONE_TRIG_BIT]  = st.trig[1];
                read_mux[`EIC_TC_ONE_PEND_BIT]  = ext_irq_one_pending; // [RL8]
            end
            default: begin
                read_mux = `EIC_RST_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_prio) begin
            // Upper nibble is dropped on write
            next_st.prio = sfr_wdata_in[`EIC_PRIO_W-1:0]; // [RL1]
        end
        if (wr_cfg) begin
            next_st.pin_cfg = sfr_wdata_in;
        end
        if (wr_tc) begin
            next_st.trig[0] = sfr_wdata_in[`EIC_TC_ZERO_TRIG_BIT]; // [RL6]
            next_st.trig[1] = sfr_wdata_in[`EIC_TC_ONE_TRIG_BIT]; // [RL6]
        end
        if (sfr_rd_in) begin
            next_st.rdata = read_mux;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st.prio    <= `EIC_RST_PRIO_TWO;
            st.pin_cfg <= `EIC_RST_PIN_CONFIG;
            st.trig    <= `EIC_RST_TRIGGER;
            st.rdata   <= `EIC_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // External interrupt channels
    // ------------------------------------------------------------
    // Level mode relies on the source holding its level [RL11] [RL12]
    eic_channel #(
        .PIN_COUNT (PIN_COUNT),
        .SEL_W     (SEL_W)
    ) u_zero (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .pin_select_in   (st.pin_cfg[`EIC_CFG_ZERO_SEL_HI:
                                     `EIC_CFG_ZERO_SEL_LO]), // [RL14]
        .polarity_in     (st.pin_cfg[`EIC_CFG_ZERO_POL_BIT]),
        .trigger_type_in (eic_trig_e'(st.trig[0])),
        .port_pins_in    (port_pins_in),
        .vector_ack_in   (ext_irq_zero_vector_in),
        .flag_wr_in      (wr_tc),
        .flag_wdata_in   (sfr_wdata_in[`EIC_TC_ZERO_PEND_BIT]),
        .pending_out     (ext_irq_zero_pending)
    );

    eic_channel #(
        .PIN_COUNT (PIN_COUNT),
        .SEL_W     (SEL_W)
    ) u_one (
        .ref_clk_in      (ref_clk_in),
        .rst_n_in        (rst_n_in),
        .pin_select_in   (st.pin_cfg[`EIC_CFG_ONE_SEL_HI:
                                     `EIC_CFG_ONE_SEL_LO]), // [RL14]
        .polarity_in     (st.pin_cfg[`EIC_CFG_ONE_POL_BIT]),
        .trigger_type_in (eic_trig_e'(st.trig[1])),
        .port_pins_in    (port_pins_in),
        .vector_ack_in   (ext_irq_one_vector_in),
        .flag_wr_in      (wr_tc),
        .flag_wdata_in   (sfr_wdata_in[`EIC_TC_ONE_PEND_BIT]),
        .pending_out     (ext_irq_one_pending)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sfr_rdata_out            = st.rdata;
    assign ext_irq_zero_pending_out = ext_irq_zero_pending;
    assign ext_irq_one_pending_out  = ext_irq_one_pending;
    assign second_serial_port_priority_out =
        st.prio[`EIC_PRIO_SPI_BIT]; // [RL2]
    assign rtc_osc_fail_priority_out =
        st.prio[`EIC_PRIO_RTC_BIT]; // [RL3]
    assign port_match_priority_out =
        st.prio[`EIC_PRIO_MATCH_BIT]; // [RL4]
    assign supply_warning_priority_out =
        st.prio[`EIC_PRIO_WARN_BIT]; // [RL5]

endmodule

// file: verif/eic_top_assertions.sv
`timescale 1ns/1ns
module eic_top_assertions #(
    parameter int PIN_COUNT = 8,
    parameter int SEL_W     = 3
) (
    // Clock, reset, register access
    input wire logic                 ref_clk_in,
    input wire logic                 rst_n_in,
    input wire logic [7:0]           sfr_addr_in,
    input wire logic                 sfr_wr_in,
    input wire logic [7:0]           sfr_wdata_in,
    input wire logic                 sfr_rd_in,
    input wire logic [7:0]           sfr_rdata_out,
    // Pins and requests
    input wire logic [PIN_COUNT-1:0] port_pins_in,
    input wire logic                 ext_irq_zero_vector_in,
    input wire logic                 ext_irq_zero_pending_out,
    input wire logic                 ext_irq_one_pending_out,
    // Priorities
    input wire logic                 second_serial_port_priority_out,
    input wire logic                 rtc_osc_fail_priority_out,
    input wire logic                 port_match_priority_out,
    input wire logic                 supply_warning_priority_out
);
    // ------------------------------------------------------------
    // Shadow copies of configuration seen on the bus
    // ------------------------------------------------------------
    logic [7:0] cfg;
    logic [1:0] trig;
    wire        wr_prio = sfr_wr_in && sfr_addr_in == 8'hf7;
    wire        act0 = port_pins_in[cfg[2:0]] == cfg[3];
    wire        act1 = port_pins_in[cfg[6:4]] == cfg[7];
    wire [3:0]  prio = {second_serial_port_priority_out,
        rtc_osc_fail_priority_out, port_match_priority_out,
        supply_warning_priority_out};
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
        if (!rst_n_in) cfg <= 8'h01;
        else if (sfr_wr_in && sfr_addr_in == 8'he4) cfg <= sfr_wdata_in;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
        if (!rst_n_in) trig <= 2'h0;
        else if (sfr_wr_in && sfr_addr_in == 8'h88)
            trig <= {sfr_wdata_in[2], sfr_wdata_in[0]};
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_rise0;
        trig[0] && !sfr_wr_in && !act0 ##1 act0;
    endsequence
    AST_PRIO_READ: assert property (
        sfr_rd_in && sfr_addr_in == 8'hf7 |=>
        sfr_rdata_out == $past({4'h0, prio})) else $error("prio read");
    AST_PRIO_SPI: assert property (
        wr_prio |=> prio[3] == $past(sfr_wdata_in[3])) else $error("spi");
    AST_PRIO_RTC: assert property (
        wr_prio |=> prio[2] == $past(sfr_wdata_in[2])) else $error("rtc");
    AST_PRIO_MATCH: assert property (
        wr_prio |=> prio[1] == $past(sfr_wdata_in[1])) else $error("match");
    AST_PRIO_WARN: assert property (
        wr_prio |=> prio[0] == $past(sfr_wdata_in[0])) else $error("warn");
    AST_LEVEL_ZERO: assert property (
        !trig[0] && !sfr_wr_in |=> ext_irq_zero_pending_out == $past(act0))
        else $error("level zero");
    AST_LEVEL_ONE: assert property (
        !trig[1] && !sfr_wr_in |=> ext_irq_one_pending_out == $past(act1))
        else $error("level one");
    AST_EDGE_SET: assert property (
        s_rise0 |=> ext_irq_zero_pending_out) else $error("edge set");
    AST_EDGE_CLEAR: assert property (
        trig[0] && ext_irq_zero_vector_in && !act0 && !sfr_wr_in |=>
        !ext_irq_zero_pending_out) else $error("edge clear");
    AST_TC_READ: assert property (
        sfr_rd_in && sfr_addr_in == 8'h88 |=> sfr_rdata_out ==
        $past({4'h0, ext_irq_one_pending_out, trig[1],
        ext_irq_zero_pending_out, trig[0]})) else $error("tc read");
endmodule

bind eic_top eic_top_assertions #(.PIN_COUNT(PIN_COUNT), .SEL_W(SEL_W))
    i_chk (.*);

// file: verif/eic_irq_source.sv
`timescale 1ns/1ns
module eic_irq_source (
    // Clock and CPU acknowledge
    input  wire logic       ref_clk_in,
    input  wire logic       vector_in,
    // Port 0 pins, all high at start, driven to the inactive level when idle
    output logic      [7:0] pins_out
);
    initial pins_out = 8'hff;
    task automatic idle(input int idx, input logic pol);
        pins_out[idx] <= ~pol;
    endtask
    task automatic level(input int idx, input logic pol);
        pins_out[idx] <= pol;
        @(posedge ref_clk_in iff vector_in);
        pins_out[idx] <= ~pol;
    endtask
    task automatic pulse(input int idx, input logic pol);
        pins_out[idx] <= pol;
        repeat (3) @(posedge ref_clk_in);
        pins_out[idx] <= ~pol;
    endtask
endmodule

// file: verif/external_interrupt_config_test.sv
`timescale 1ns/1ns
module external_interrupt_config_test;
    logic       ref_clk_in = 1'b0;
    logic       rst_n_in = 1'b0;
    logic [7:0] sfr_addr_in = 8'h00;
    logic       sfr_wr_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic       sfr_rd_in = 1'b0;
    logic [7:0] sfr_rdata_out;
    logic [7:0] pins;
    logic [1:0] vec = 2'h0;
    wire  [1:0] pend;
    wire  [3:0] prio;
    logic [7:0] rd;
    logic [7:0] adr[4] = '{8'hf7, 8'he4, 8'h88, 8'h55};
    logic [7:0] rst_val[4] = '{8'h00, 8'h01, 8'h00, 8'h00};
    int         errors = 0;
    int         checked = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    eic_irq_source src (.ref_clk_in(ref_clk_in), .vector_in(|vec),
        .pins_out(pins));
    eic_top i_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
        .sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out), .port_pins_in(pins),
        .ext_irq_zero_vector_in(vec[0]), .ext_irq_one_vector_in(vec[1]),
        .ext_irq_zero_pending_out(pend[0]),
        .ext_irq_one_pending_out(pend[1]),
        .second_serial_port_priority_out(prio[3]),
        .rtc_osc_fail_priority_out(prio[2]),
        .port_match_priority_out(prio[1]),
        .supply_warning_priority_out(prio[0]));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_wdata_in <= d;
        sfr_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_wr_in <= 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        sfr_addr_in <= a;
        sfr_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        sfr_rd_in <= 1'b0;
        // Read data is registered: take it at the following edge
        @(posedge ref_clk_in);
        d = sfr_rdata_out;
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Edge and level cases each finish in well under 60 cycles
    initial begin
        repeat (3000) @(posedge ref_clk_in);
        errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            sfr_read(adr[i], rd);
            chk(rd, rst_val[i]);
        end
        $display("test reset values done");
        for (int b = 0; b < 4; b++) begin
            sfr_write(8'hf7, 8'hf0 | (8'h01 << b));
            sfr_read(8'hf7, rd);
            chk(rd, 8'h01 << b);
            chk({4'h0, prio}, 8'h01 << b);
        end
        $display("test priority done");
        for (int c = 0; c < 2; c++) begin
            for (int m = 0; m < 4; m++) begin
                automatic int idx = c * 4 + m;
                automatic logic pol = m[0];
                automatic logic edg = m[1];
                automatic logic [3:0] cf = {pol, idx[2:0]};
                src.idle(idx, pol);
                sfr_write(8'he4, c ? {cf, 4'h0} : {4'h0, cf});
                sfr_write(8'h88,
                          {5'h0, edg & c[0], 1'b0, edg & ~c[0]});
                repeat (2) @(posedge ref_clk_in);
                chk({7'h0, pend[c]}, 8'h00);
                fork
                    if (edg) src.pulse(idx, pol);
                    else src.level(idx, pol);
                    begin
                        for (int i = 0; i < 8 && pend[c] !== 1'b1; i++)
                            @(posedge ref_clk_in);
                        chk({7'h0, pend[c]}, 8'h01);
                        sfr_read(8'h88, rd);
                        chk((rd >> (2 * c)) & 8'h03,
                            {6'h0, 1'b1, edg});
                        @(posedge ref_clk_in);
                        vec[c] <= 1'b1;
                        @(posedge ref_clk_in);
                        vec[c] <= 1'b0;
                    end
                join
                repeat (3) @(posedge ref_clk_in);
                chk({7'h0, pend[c]}, 8'h00);
            end
        end
        $display("test pin modes done");
        summarize();
    end
endmodule
